//--- core/pfs_port_function_select.sv
// pfs_port_function_select: per-pin function multiplexing for ports 0, 1 and 2
// assumes avalon-mm master on i_core_clk; peripheral signals synchronous to the same clock
module pfs_port_function_select
  import pfs_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_sw_reset,
  // avalon-mm slave
  input  wire logic [PFS_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  output logic      [1:0]            o_avs_response,
  // output data registers of each port
  input  wire logic [7:0]            i_port0_output_data,
  input  wire logic [7:0]            i_port1_output_data,
  input  wire logic [7:0]            i_port2_output_data,
  // pin inputs
  input  wire logic [7:0]            i_port0_pin,
  input  wire logic [7:0]            i_port1_pin,
  input  wire logic [7:0]            i_port2_pin,
  // peripheral outputs toward pins
  input  wire logic                  i_spi_data_out,
  input  wire logic                  i_spi_clock,
  input  wire logic                  i_primary_uart_transmit,
  input  wire logic                  i_second_uart_transmit,
  input  wire logic                  i_timer_pulse_out_a,
  input  wire logic                  i_timer_pulse_out_b,
  input  wire logic                  i_second_i2c_clock_out,
  input  wire logic                  i_second_i2c_clock_oe,
  input  wire logic                  i_second_i2c_data_out,
  input  wire logic                  i_second_i2c_data_oe,
  input  wire logic                  i_first_i2c_clock_out,
  input  wire logic                  i_first_i2c_clock_oe,
  input  wire logic                  i_first_i2c_data_out,
  input  wire logic                  i_first_i2c_data_oe,
  input  wire logic                  i_buffered_crystal_clock,
  input  wire logic                  i_pcm_frame_sync,
  input  wire logic                  i_slot_frame_signal,
  input  wire logic                  i_pcm_data_out,
  input  wire logic                  i_pcm_open_drain,
  input  wire logic                  i_pcm_clock,
  input  wire logic                  i_debug_port_bit3,
  input  wire logic                  i_debug_port_bit2,
  input  wire logic                  i_hundred_clock_output,
  input  wire logic                  i_echo_control_out_a,
  input  wire logic                  i_echo_control_out_b,
  input  wire logic                  i_led_current_source_a,
  input  wire logic                  i_led_current_source_b,
  input  wire logic [4:0]            i_radio_out,
  input  wire logic                  i_radio_bidir_oe,
  // pins
  output logic      [7:0]            o_port0_pin,
  output logic      [7:0]            o_port0_oe,
  output logic      [7:0]            o_port1_pin,
  output logic      [7:0]            o_port1_oe,
  output logic      [7:0]            o_port2_pin,
  output logic      [7:0]            o_port2_oe,
  output logic      [2:0]            o_port1_weak_drive,
  output logic      [7:0]            o_pull_up,
  output logic      [7:0]            o_pull_down,
  output logic                       o_analog_converter_input_1,
  // peripheral inputs from pins; led pwm enables come from the pad control register
  output logic                       o_spi_data_in,
  output logic                       o_spi_enable_in,
  output logic                       o_pcm_data_in,
  output logic                       o_processor_load_monitor_input,
  output logic      [4:0]            o_radio_in,
  output logic                       o_irq7_in,
  output logic                       o_irq6_in,
  output logic      [1:0]            o_led_pwm_enable
);

  logic [15:0] p0_q;
  logic [15:0] p1_q;
  logic [15:0] p2_q;
  logic [15:0] dir_q;
  logic [15:0] pad_q;
  logic [23:0] idx;
  logic        hit0, hit1, hit2, hitd, hitp, hit_any;
  logic [15:0] wdat;
  logic        wlo, whi;
  logic        busy_q;

  assign idx     = i_avs_address[PFS_ADDR_W-1:2];
  assign wdat    = i_avs_writedata[15:0];
  assign wlo     = i_avs_byteenable[0];
  assign whi     = i_avs_byteenable[1];

  always_comb begin
    hit0 = 1'b0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    hitd = 1'b0;
    hitp = 1'b0;
    if (idx == PFS_P0_IDX) begin
      hit0 = 1'b1;
    end else if (idx == PFS_P1_IDX) begin
      hit1 = 1'b1;
    end else if (idx == PFS_P2_IDX) begin
      hit2 = 1'b1;
    end else if (idx == PFS_DIR_IDX) begin
      hitd = 1'b1;
    end else if (idx == PFS_PAD_IDX) begin
      hitp = 1'b1;
    end
  end
  assign hit_any = hit0 | hit1 | hit2 | hitd | hitp;

  // byte-lane merge under a writable mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic lo, input logic hi, input logic [15:0] msk);
    logic [15:0] be;
    be = {{8{hi}}, {8{lo}}} & msk;
    return (old & ~be) | (nw & be);
  endfunction

  // one wait cycle per access, then the answer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
    end
  end
  assign busy_q = ~o_avs_waitrequest;

  // mode registers: hardware reset only, software reset ignored
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      p0_q  <= PFS_P0_RST;
      p1_q  <= PFS_P1_RST;
      p2_q  <= PFS_P2_RST;
      dir_q <= PFS_DIR_RST;
      pad_q <= PFS_PAD_RST;
    end else if (i_avs_write && busy_q) begin
      if (hit0) begin
        p0_q <= merge(p0_q, wdat, wlo, whi, PFS_P0_WMASK);
      end
      if (hit1) begin
        p1_q <= merge(p1_q, wdat, wlo, whi, PFS_P1_WMASK);
      end
      if (hit2) begin
        p2_q <= merge(p2_q, wdat, wlo, whi, 16'hffff);
      end
      if (hitd) begin
        dir_q <= merge(dir_q, wdat, wlo, whi, 16'hffff);
      end
      if (hitp) begin
        pad_q <= merge(pad_q, wdat, wlo, whi, PFS_PAD_WMASK);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_readdata <= 32'h0;
      o_avs_response <= 2'h0;
    end else if (i_avs_read && !busy_q) begin
      o_avs_response <= hit_any ? 2'h0 : 2'h3;
      if (hit0) begin
        o_avs_readdata <= {16'h0, p0_q};
      end else if (hit1) begin
        o_avs_readdata <= {16'h0, p1_q};
      end else if (hit2) begin
        o_avs_readdata <= {16'h0, p2_q};
      end else if (hitd) begin
        o_avs_readdata <= {16'h0, dir_q};
      end else if (hitp) begin
        o_avs_readdata <= {16'h0, pad_q};
      end else begin
        o_avs_readdata <= 32'h0;
      end
    end else if (i_avs_write && !busy_q) begin
      o_avs_response <= hit_any ? 2'h0 : 2'h3;
    end
  end

  // direction field of port 1 (software owned): code 11 output, 01 input with pull-up, 10 input with pull-down, 00 input without pull
  logic [7:0] dir_out, pu, pd;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      dir_out[k] = (dir_q[2*k +: 2] == PFS_DIR_OUT);
      pu[k]      = (dir_q[2*k +: 2] == PFS_DIR_PU);
      pd[k]      = (dir_q[2*k +: 2] == PFS_DIR_PD);
    end
  end

  // next pin values
  logic [7:0] p0_d, p0_oe_d, p1_d, p1_oe_d, p2_d, p2_oe_d;
  logic [1:0] rf;
  always_comb begin
    p0_d    = i_port0_output_data;
    p0_oe_d = 8'hff;
    p1_d    = i_port1_output_data;
    p1_oe_d = dir_out;
    p2_d    = i_port2_output_data;
    p2_oe_d = 8'hff;
    rf      = p1_q[PFS_P1_RFBB +: 2];
    case (p0_q[13:12])
      PFS_FN_ALT1: p0_oe_d[7] = 1'b0;
      PFS_FN_ALT2: p0_d[7] = i_timer_pulse_out_b;
      default: ;
    endcase
    if (p0_q[11:10] == PFS_FN_ALT1) p0_d[6] = i_spi_data_out;
    if (p0_q[9:8] == PFS_FN_ALT1) p0_d[5] = i_spi_clock;
    if (p0_q[7:6] == PFS_FN_ALT1) p0_oe_d[4] = 1'b0;
    if (p0_q[5:4] == PFS_FN_ALT1) begin
      p0_d[3]    = i_second_i2c_clock_out;
      p0_oe_d[3] = i_second_i2c_clock_oe;
    end
    case (p0_q[3:2])
      PFS_FN_ALT1: begin
        p0_d[2]    = i_second_i2c_data_out;
        p0_oe_d[2] = i_second_i2c_data_oe;
      end
      PFS_FN_ALT2: p0_d[2] = i_second_uart_transmit;
      default: ;
    endcase
    if (p0_q[1]) p0_d[1] = i_timer_pulse_out_a;
    if (p0_q[0]) p0_d[0] = i_primary_uart_transmit;
    // radio baseband takes pins 1..5
    if (rf == PFS_RF_OUT || rf == PFS_RF_BIDIR) begin
      p1_d[5:1]    = i_radio_out;
      p1_oe_d[5:1] = 5'h1f;
      if (rf == PFS_RF_BIDIR) begin
        p1_oe_d[5] = 1'b0;
        p1_oe_d[3] = i_radio_bidir_oe;
      end
    end
    if (p1_q[PFS_P1_ADC]) begin
      p1_oe_d[0] = 1'b0;
    end
    if (p2_q[PFS_P2_P7]) p2_d[7] = i_buffered_crystal_clock;
    if (p2_q[PFS_P2_P6]) p2_oe_d[6] = 1'b0;
    case (p2_q[11:10])
      PFS_FN_ALT1: p2_d[5] = i_pcm_frame_sync;
      PFS_FN_ALT2: p2_d[5] = i_slot_frame_signal;
      default: ;
    endcase
    case (p2_q[9:8])
      PFS_FN_ALT1: begin
        p2_d[4]    = i_pcm_open_drain ? 1'b0 : i_pcm_data_out;
        p2_oe_d[4] = i_pcm_open_drain ? ~i_pcm_data_out : 1'b1;
      end
      PFS_FN_ALT2: begin
        p2_d[4]    = i_first_i2c_clock_out;
        p2_oe_d[4] = i_first_i2c_clock_oe;
      end
      PFS_FN_ALT3: p2_d[4] = i_debug_port_bit3;
      default: ;
    endcase
    case (p2_q[7:6])
      PFS_FN_ALT1: p2_oe_d[3] = 1'b0;
      PFS_FN_ALT2: begin
        p2_d[3]    = i_first_i2c_data_out;
        p2_oe_d[3] = i_first_i2c_data_oe;
      end
      PFS_FN_ALT3: p2_d[3] = i_debug_port_bit2;
      default: ;
    endcase
    case (p2_q[5:4])
      PFS_FN_ALT1: p2_d[2] = i_pcm_clock;
      PFS_FN_ALT2: p2_d[2] = i_hundred_clock_output;
      default: ;
    endcase
    case (p2_q[3:2])
      PFS_FN_ALT1: p2_d[1] = i_echo_control_out_b;
      PFS_FN_ALT2: p2_d[1] = i_timer_pulse_out_b;
      PFS_FN_ALT3: p2_d[1] = i_led_current_source_b;
      default: ;
    endcase
    case (p2_q[1:0])
      PFS_FN_ALT1: p2_d[0] = i_echo_control_out_a;
      PFS_FN_ALT2: p2_d[0] = i_timer_pulse_out_a;
      PFS_FN_ALT3: p2_d[0] = i_led_current_source_a;
      default: ;
    endcase
    // open-drain pins drive only low
    if (pad_q[PFS_PAD_OD0]) begin
      p2_oe_d[0] = p2_oe_d[0] & ~p2_d[0];
    end
    if (pad_q[PFS_PAD_OD1]) begin
      p2_oe_d[1] = p2_oe_d[1] & ~p2_d[1];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_port0_pin <= 8'h0;
      o_port0_oe  <= 8'h0;
      o_port1_pin <= 8'h0;
      o_port1_oe  <= 8'h0;
      o_port2_pin <= 8'h0;
      o_port2_oe  <= 8'h0;
    end else begin
      o_port0_pin <= p0_d;
      o_port0_oe  <= p0_oe_d;
      o_port1_pin <= p1_d;
      o_port1_oe  <= p1_oe_d;
      o_port2_pin <= p2_d;
      o_port2_oe  <= p2_oe_d;
    end
  end

  // pad attributes and routed inputs
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_port1_weak_drive             <= 3'h0;
      o_pull_up                      <= 8'h0;
      o_pull_down                    <= 8'h0;
      o_analog_converter_input_1     <= 1'b1;
      o_led_pwm_enable               <= 2'h0;
    end else begin
      o_port1_weak_drive             <= {p1_q[PFS_P1_DRV4], p1_q[PFS_P1_DRV3], 1'b0};
      o_pull_up                      <= p1_q[PFS_P1_ADC] ? {pu[7:1], 1'b0} : pu;
      o_pull_down                    <= p1_q[PFS_P1_ADC] ? {pd[7:1], 1'b0} : pd;
      o_analog_converter_input_1     <= p1_q[PFS_P1_ADC] & ~dir_out[0];
      o_led_pwm_enable               <= {pad_q[PFS_PAD_PWMB], pad_q[PFS_PAD_PWMA]};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_spi_data_in                  <= 1'b0;
      o_spi_enable_in                <= 1'b0;
      o_pcm_data_in                  <= 1'b0;
      o_processor_load_monitor_input <= 1'b0;
      o_radio_in                     <= 5'h0;
      o_irq7_in                      <= 1'b0;
      o_irq6_in                      <= 1'b0;
    end else begin
      o_spi_data_in                  <= (p0_q[13:12] == PFS_FN_ALT1) & i_port0_pin[7];
      o_spi_enable_in                <= (p0_q[7:6] == PFS_FN_ALT1) & i_port0_pin[4];
      o_pcm_data_in                  <= (p2_q[7:6] == PFS_FN_ALT1) & i_port2_pin[3];
      o_processor_load_monitor_input <= p2_q[PFS_P2_P6] & i_port2_pin[6];
      o_radio_in                     <= (rf == PFS_RF_BIDIR) ? i_port1_pin[5:1] : 5'h0;
      o_irq7_in <= p2_q[PFS_P2_IRQ7] ? i_port1_pin[2] : i_port2_pin[7];
      o_irq6_in <= p2_q[PFS_P2_IRQ6] ? i_port1_pin[1] : i_port2_pin[6];
    end
  end

endmodule // pfs_port_function_select

//--- core/pfs_pkg.sv
// pfs_pkg: register map, field positions and function codes of the port function select block
// assumes a 16-bit register view mapped onto 32-bit avalon words
package pfs_pkg;
  // printed offsets are not all multiples of four: kept as indices, byte address is four times
  localparam logic [23:0] PFS_P0_IDX       = 24'hff4838;
  localparam logic [23:0] PFS_P1_IDX       = 24'hff4848;
  localparam logic [23:0] PFS_P2_IDX       = 24'hff4858;
  localparam logic [23:0] PFS_DIR_IDX      = 24'hff4880;
  localparam logic [23:0] PFS_PAD_IDX      = 24'hff4881;
  localparam int          PFS_ADDR_W       = 26;
  localparam logic [15:0] PFS_P0_RST       = 16'h0000;
  localparam logic [15:0] PFS_P1_RST       = 16'h0001;
  localparam logic [15:0] PFS_P2_RST       = 16'h0000;
  localparam logic [15:0] PFS_DIR_RST      = 16'h0000;
  localparam logic [15:0] PFS_PAD_RST      = 16'h0003;
  localparam logic [15:0] PFS_P0_WMASK     = 16'h3fff;
  localparam logic [15:0] PFS_P1_WMASK     = 16'h0319;
  localparam logic [15:0] PFS_PAD_WMASK    = 16'h000f;
  // pad control bits
  localparam int          PFS_PAD_OD0      = 0;
  localparam int          PFS_PAD_OD1      = 1;
  localparam int          PFS_PAD_PWMA     = 2;
  localparam int          PFS_PAD_PWMB     = 3;
  // port 1 field positions
  localparam int          PFS_P1_RFBB      = 8;
  localparam int          PFS_P1_DRV4      = 4;
  localparam int          PFS_P1_DRV3      = 3;
  localparam int          PFS_P1_ADC       = 0;
  // port 2 single bits
  localparam int          PFS_P2_P7        = 15;
  localparam int          PFS_P2_IRQ7      = 14;
  localparam int          PFS_P2_P6        = 13;
  localparam int          PFS_P2_IRQ6      = 12;
  // two-bit function codes
  localparam logic [1:0]  PFS_FN_DATA      = 2'h0;
  localparam logic [1:0]  PFS_FN_ALT1      = 2'h1;
  localparam logic [1:0]  PFS_FN_ALT2      = 2'h2;
  localparam logic [1:0]  PFS_FN_ALT3      = 2'h3;
  // direction codes and radio baseband modes
  localparam logic [1:0]  PFS_DIR_IN       = 2'h0;
  localparam logic [1:0]  PFS_DIR_PU       = 2'h1;
  localparam logic [1:0]  PFS_DIR_PD       = 2'h2;
  localparam logic [1:0]  PFS_DIR_OUT      = 2'h3;
  localparam logic [1:0]  PFS_RF_OFF       = 2'h0;
  localparam logic [1:0]  PFS_RF_OUT       = 2'h1;
  localparam logic [1:0]  PFS_RF_BIDIR     = 2'h2;
endpackage : pfs_pkg

//--- tb/pfs_port_function_select_props.sv
// pfs_props: checks pin routing, interrupt sources and bus wait timing
// assumes bind onto pfs_port_function_select; shadows follow accepted writes
module pfs_props
  import pfs_pkg::*;
(
  input wire logic                  i_core_clk,
  input wire logic                  i_rst_b,
  input wire logic [PFS_ADDR_W-1:0] i_avs_address,
  input wire logic                  i_avs_read,
  input wire logic                  i_avs_write,
  input wire logic [31:0]           i_avs_writedata,
  input wire logic [3:0]            i_avs_byteenable,
  input wire logic                  o_avs_waitrequest,
  input wire logic [7:0]            i_port0_output_data,
  input wire logic [7:0]            i_port2_output_data,
  input wire logic [7:0]            i_port0_pin,
  input wire logic [7:0]            i_port1_pin,
  input wire logic [7:0]            i_port2_pin,
  input wire logic                  i_primary_uart_transmit,
  input wire logic                  i_timer_pulse_out_a,
  input wire logic                  i_timer_pulse_out_b,
  input wire logic                  i_buffered_crystal_clock,
  input wire logic [7:0]            o_port0_pin,
  input wire logic [7:0]            o_port2_pin,
  input wire logic                  o_spi_data_in,
  input wire logic                  o_spi_enable_in,
  input wire logic                  o_irq7_in,
  input wire logic                  o_irq6_in
);
  logic [15:0] sh0_q;
  logic [15:0] sh2_q;
  logic        live_q;
  logic        acc;
  logic [15:0] lane;
  logic [23:0] idx;
  logic [7:0]  ex;
  assign acc  = i_avs_write && !o_avs_waitrequest;
  assign ex   = {sh0_q[0] ? i_primary_uart_transmit : i_port0_output_data[0],
                 sh0_q[1] ? i_timer_pulse_out_a : i_port0_output_data[1],
                 sh0_q[13:12] == 2'h2 ? i_timer_pulse_out_b : i_port0_output_data[7],
                 sh0_q[13:12] == 2'h1 && i_port0_pin[7],
                 sh0_q[7:6] == 2'h1 && i_port0_pin[4],
                 sh2_q[15] ? i_buffered_crystal_clock : i_port2_output_data[7],
                 sh2_q[14] ? i_port1_pin[2] : i_port2_pin[7],
                 sh2_q[12] ? i_port1_pin[1] : i_port2_pin[6]};
  assign lane = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign idx  = i_avs_address[PFS_ADDR_W-1:2];
  // software reset deliberately ignored
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) sh0_q <= PFS_P0_RST;
    else if (acc && idx == PFS_P0_IDX) sh0_q <= (sh0_q & ~(lane & PFS_P0_WMASK)) |
                                                (i_avs_writedata[15:0] & lane & PFS_P0_WMASK);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) sh2_q <= PFS_P2_RST;
    else if (acc && idx == PFS_P2_IDX) sh2_q <= (sh2_q & ~lane) | (i_avs_writedata[15:0] & lane);
  end
  // outputs carry reset values on the first edge after release
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  chk_p0_uart_route: assert property (live_q |->
    o_port0_pin[0] == $past(ex[7])) else $error("p0 pin0 route");
  chk_p0_pwm_route: assert property (live_q |->
    o_port0_pin[1] == $past(ex[6])) else $error("p0 pin1 route");
  chk_p0_pin7_route: assert property (live_q && $past(sh0_q[13:12]) != 2'h1 |->
    o_port0_pin[7] == $past(ex[5])) else $error("p0 pin7 route");
  chk_spi_data_in: assert property (live_q |->
    o_spi_data_in == $past(ex[4])) else $error("spi data in route");
  chk_spi_enable_in: assert property (live_q |->
    o_spi_enable_in == $past(ex[3])) else $error("spi enable route");
  chk_p2_xtal_route: assert property (live_q |->
    o_port2_pin[7] == $past(ex[2])) else $error("p2 pin7 route");
  chk_irq7_source: assert property (live_q |->
    o_irq7_in == $past(ex[1])) else $error("irq7 source");
  chk_irq6_source: assert property (live_q |->
    o_irq6_in == $past(ex[0])) else $error("irq6 source");
  chk_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus wait length");
endmodule // pfs_props

bind pfs_port_function_select pfs_props u_props (.*);

//--- tb/pfs_periph_model.sv
// pfs_periph_model: peripheral blocks, far pins and data registers around the mux
// assumes one clock; levels hold still while i_run is low
module pfs_periph_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_run,
  output logic      [32:0] o_sig,
  output logic      [23:0] o_ext,
  output logic      [23:0] o_odat
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 35;
  initial begin
    o_sig  = '0;
    o_ext  = '0;
    o_odat = '0;
  end
  always @(posedge i_core_clk) begin
    if (i_run) begin
      o_sig  <= 33'({$random(seed), $random(seed)});
      o_ext  <= 24'($random(seed));
      o_odat <= 24'($random(seed));
    end
  end
endmodule // pfs_periph_model

//--- tb/pfs_port_function_select_test.sv
// pfs_port_function_select_test: self-checking bench with a register and routing model
// assumes pfs_props bound to the design and pfs_periph_model around it
module pfs_port_function_select_test;
  import pfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  i_core_clk = 1'b0;
  logic                  i_rst_b = 1'b0;
  logic                  i_sw_reset = 1'b0;
  logic                  i_avs_read = 1'b0;
  logic                  i_avs_write = 1'b0;
  logic [PFS_ADDR_W-1:0] i_avs_address = '0;
  logic [31:0]           i_avs_writedata = '0;
  logic [3:0]            i_avs_byteenable = 4'hf;
  logic [7:0]            i_port0_output_data, i_port1_output_data, i_port2_output_data;
  logic [7:0]            i_port0_pin, i_port1_pin, i_port2_pin;
  logic i_spi_data_out, i_spi_clock, i_primary_uart_transmit, i_second_uart_transmit, i_timer_pulse_out_a;
  logic i_timer_pulse_out_b, i_second_i2c_clock_out, i_second_i2c_clock_oe, i_second_i2c_data_out;
  logic i_second_i2c_data_oe, i_first_i2c_clock_out, i_first_i2c_clock_oe, i_first_i2c_data_out;
  logic i_first_i2c_data_oe, i_buffered_crystal_clock, i_pcm_frame_sync, i_slot_frame_signal, i_pcm_data_out;
  logic i_pcm_open_drain, i_pcm_clock, i_debug_port_bit3, i_debug_port_bit2, i_hundred_clock_output;
  logic i_echo_control_out_a, i_echo_control_out_b, i_led_current_source_a, i_led_current_source_b;
  logic [4:0]            i_radio_out;
  logic                  i_radio_bidir_oe;
  logic [31:0]           o_avs_readdata;
  logic [1:0]            o_avs_response, o_led_pwm_enable;
  logic [7:0]            o_port0_pin, o_port0_oe, o_port1_pin, o_port1_oe, o_port2_pin, o_port2_oe;
  logic [7:0]            o_pull_up, o_pull_down;
  logic [4:0]            o_radio_in;
  logic [2:0]            o_port1_weak_drive;
  logic o_avs_waitrequest, o_analog_converter_input_1, o_spi_data_in, o_spi_enable_in, o_pcm_data_in;
  logic o_processor_load_monitor_input, o_irq7_in, o_irq6_in;
  logic                  run = 1'b1;
  logic [32:0]           sig;
  logic [23:0]           ext, odat;
  int                    n_mismatch = 0;
  int                    n_tests = 0;
  int                    mdl [5];
  logic [23:0]           idxs [5] = '{PFS_P0_IDX, PFS_P1_IDX, PFS_P2_IDX, PFS_DIR_IDX, PFS_PAD_IDX};
  logic [15:0]           wmsk [5] = '{PFS_P0_WMASK, PFS_P1_WMASK, 16'hffff, 16'hffff, PFS_PAD_WMASK};
  logic [15:0]           rstv [5] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0003};

  always #5 i_core_clk = ~i_core_clk;
  pfs_periph_model i_peer (.i_core_clk(i_core_clk), .i_run(run), .o_sig(sig), .o_ext(ext), .o_odat(odat));
  assign {i_spi_data_out, i_spi_clock, i_primary_uart_transmit, i_second_uart_transmit, i_timer_pulse_out_a,
          i_timer_pulse_out_b, i_second_i2c_clock_out, i_second_i2c_clock_oe, i_second_i2c_data_out,
          i_second_i2c_data_oe, i_first_i2c_clock_out, i_first_i2c_clock_oe, i_first_i2c_data_out,
          i_first_i2c_data_oe, i_buffered_crystal_clock, i_pcm_frame_sync, i_slot_frame_signal, i_pcm_data_out,
          i_pcm_open_drain, i_pcm_clock, i_debug_port_bit3, i_debug_port_bit2, i_hundred_clock_output,
          i_echo_control_out_a, i_echo_control_out_b, i_led_current_source_a, i_led_current_source_b,
          i_radio_out, i_radio_bidir_oe} = sig;
  assign {i_port2_output_data, i_port1_output_data, i_port0_output_data} = odat;
  // pin level seen by everyone: own driver wins, else the far end
  assign i_port0_pin = (o_port0_oe & o_port0_pin) | (~o_port0_oe & ext[7:0]);
  assign i_port1_pin = (o_port1_oe & o_port1_pin) | (~o_port1_oe & ext[15:8]);
  assign i_port2_pin = (o_port2_oe & o_port2_pin) | (~o_port2_oe & ext[23:16]);
  pfs_port_function_select i_dut (.*);

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [23:0] ix, input logic [15:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_avs_address    <= {ix, 2'h0};
    i_avs_writedata  <= {16'h0, wd};
    i_avs_byteenable <= be;
    i_avs_read       <= !wr;
    i_avs_write      <= wr;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    if (o_avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      final_report();
    end
  endtask

  task automatic wreg(input int r, input logic [15:0] wd, input logic [3:0] be);
    logic [31:0] rd;
    logic [15:0] ln;
    ln = {{8{be[1]}}, {8{be[0]}}} & wmsk[r];
    acc(1'b1, idxs[r], wd, be, rd);
    mdl[r] = (mdl[r] & ~int'(ln)) | int'(wd & ln);
  endtask

  task automatic rchk(input int r);
    logic [31:0] rd;
    acc(1'b0, idxs[r], 16'h0, 4'hf, rd);
    check(rd, {16'h0, 16'(mdl[r])});
  endtask

  function automatic logic [7:0] exp_p0(input logic [15:0] m);
    logic [7:0] e;
    e = i_port0_output_data;
    if (m[0]) e[0] = i_primary_uart_transmit;
    if (m[1]) e[1] = i_timer_pulse_out_a;
    if (m[3:2] == 2'h1) e[2] = i_second_i2c_data_out;
    if (m[3:2] == 2'h2) e[2] = i_second_uart_transmit;
    if (m[5:4] == 2'h1) e[3] = i_second_i2c_clock_out;
    if (m[9:8] == 2'h1) e[5] = i_spi_clock;
    if (m[11:10] == 2'h1) e[6] = i_spi_data_out;
    if (m[13:12] == 2'h2) e[7] = i_timer_pulse_out_b;
    return e;
  endfunction

  initial begin
    logic [31:0] rd;
    logic [15:0] v;
    logic [7:0]  mk;
    for (int r = 0; r < 5; r++) mdl[r] = rstv[r];
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    for (int r = 0; r < 5; r++) rchk(r);
    check(o_analog_converter_input_1, 32'h1);
    acc(1'b0, 24'h000001, 16'h0, 4'hf, rd);
    check({o_avs_response, rd[29:0]}, 32'hc0000000);
    for (int c = 0; c < 4; c++) begin
      v = {8{c[1:0]}};
      wreg(0, v, 4'hf);
      wreg(2, v, 4'hf);
      rchk(0);
      rchk(2);
      run <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      mk = {v[13:12] != 2'h1, 2'h3, v[7:6] != 2'h1, 4'hf};
      check(o_port0_pin & mk, exp_p0(v & PFS_P0_WMASK) & mk);
      check(o_spi_data_in, 32'(c == 1 && ext[7]));
      check(o_spi_enable_in, 32'(c == 1 && ext[4]));
      check(o_pcm_data_in, 32'(c == 1 && ext[19]));
      check(o_processor_load_monitor_input, 32'(c[1] && ext[22]));
      if (c == 1) check(o_port0_oe[2], i_second_i2c_data_oe);
      run <= 1'b1;
      repeat (20) @(posedge i_core_clk);
    end
    wreg(2, 16'ha5c3, 4'h1);
    rchk(2);
    wreg(3, 16'hd240, 4'hf);
    wreg(1, 16'hffff, 4'hf);
    rchk(1);
    wreg(1, 16'h0218, 4'hf);
    wreg(4, 16'h000f, 4'hf);
    run <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    check(o_port1_weak_drive[2:1], 32'h3);
    check(o_analog_converter_input_1, 32'h0);
    check(o_radio_in, {ext[13], i_radio_out[3], i_radio_bidir_oe ? i_radio_out[2] : ext[11], i_radio_out[1:0]});
    check(o_port1_pin[5:1], i_radio_out);
    check(o_port1_oe, {4'h9, i_radio_bidir_oe, 2'h3, 1'b0});
    check({o_pull_up, o_pull_down}, 32'h4810);
    check(o_port1_oe[5], 32'h0);
    check(o_led_pwm_enable, 32'h3);
    check(o_port2_pin[5:2], {odat[21], i_debug_port_bit3, i_debug_port_bit2, odat[18]});
    check(o_port2_pin[1:0], {odat[17], i_led_current_source_a});
    check(o_port2_oe[1:0], {~odat[17], ~i_led_current_source_a});
    wreg(1, 16'h0100, 4'hf);
    repeat (2) @(posedge i_core_clk);
    check({o_radio_in, o_port1_pin[5:1], o_port1_oe[5:1]}, {5'h0, i_radio_out, 5'h1f});
    run <= 1'b1;
    i_sw_reset <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_sw_reset <= 1'b0;
    for (int r = 0; r < 5; r++) rchk(r);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    for (int r = 0; r < 5; r++) mdl[r] = rstv[r];
    for (int r = 0; r < 5; r++) rchk(r);
    final_report();
  end
endmodule // pfs_port_function_select_test
